// ### design/power_saving_mode_control.v
// Power-saving mode controller: doze, sleep and idle sequencing.
// Assumes CPU, interrupt and watchdog signals share ref_clk; pin wakes are synchronised here.
`timescale 1ns/1ns
`include "power_mode_defs.vh"
module power_saving_mode_control
#(
  parameter OSC_PERIODS = `OSC_STARTUP_PERIODS,
  parameter LP_CYCLES = `LP_STABILISE_CYCLES
)
(
  input wire ref_clk,
  input wire rst_b,
  input wire instrTick,
  input wire oscTick,
  input wire sleepInstr,
  input wire isrEntry,
  input wire isrReturn,
  input wire nextInstrDone,
  input wire idleEnableIn,
  input wire dozeRatioWrite,
  input wire [`DOZE_RATIO_W-1:0] dozeRatioIn,
  input wire dozeCtrlWrite,
  input wire dozeEnableIn,
  input wire recoverOnInterruptIn,
  input wire dozeOnExitIn,
  input wire lowPowerSleepSelect,
  input wire globalInterruptEnable,
  input wire interruptPendingEnabled,
  input wire anyInterruptFlag,
  input wire watchdogTimeout,
  input wire watchdogSleepEnable,
  input wire resetPinWake,
  input wire brownOutWake,
  input wire crystalMode,
  input wire [7:0] portDriveIn,
  input wire [7:0] portEnableIn,
  input wire [7:0] asyncPeriphMask,
  input wire [7:0] asyncPeriphDrive,
  output reg cpuCycleEnable,
  output reg cpuHalt,
  output reg programMemoryHalt,
  output reg systemClockEnable,
  output reg peripheralClockEnable,
  output reg clockOutputEnable,
  output reg watchdogClear,
  output reg watchdogRun,
  output reg regulatorLowPower,
  output reg deviceResetRequest,
  output reg vectorRequest,
  output reg [15:0] vectorAddress,
  output reg powerDownFlag,
  output reg timeoutFlag,
  output reg dozeEnable,
  output reg recoverOnInterrupt,
  output reg dozeOnExit,
  output reg idleEnable,
  output reg [`DOZE_RATIO_W-1:0] dozeRatio,
  output reg [7:0] portDrive,
  output reg [7:0] portEnable
);
  localparam RUN = `MODE_RUN;
  localparam SLEEP = `MODE_SLEEP;
  localparam IDLE = `MODE_IDLE;
  localparam WAKE = `MODE_WAKE;
  // Pins follow the port registers while the system clock runs.
  function pinsFollow;
    input [3:0] mode;
    begin
      pinsFollow = (mode == RUN) || (mode == IDLE);
    end
  endfunction
  reg [3:0] state;
  reg [1:0] resetPinSync;
  reg [1:0] brownOutSync;
  reg vectorPending;
  reg wakeStart;
  wire throttleEnable;
  wire delayDone;
  wire resetWake;
  wire intWake;
  assign resetWake = resetPinSync[1] | brownOutSync[1];
  assign intWake = interruptPendingEnabled | (watchdogTimeout & watchdogSleepEnable);
  wire [7:0] sleepDrive;
  genvar b;
  // Each pin keeps its level unless an active asynchronous peripheral owns it.
  generate
    for (b = 0; b < 8; b = b + 1)
    begin : pinHold
      assign sleepDrive[b] = asyncPeriphMask[b] ? asyncPeriphDrive[b] : portDrive[b];
    end
  endgenerate
  doze_throttle throttle
  (
    .ref_clk(ref_clk),
    .rst_b(rst_b),
    .instrTick(instrTick),
    .dozeEnable(dozeEnable),
    .dozeRatio(dozeRatio),
    .cpuCycleEnable(throttleEnable)
  );
  // One delay block, with a counter for each, covers both the oscillator start-up and the regulator settling.
  wake_delay #(.OSC_PERIODS(OSC_PERIODS), .LP_CYCLES(LP_CYCLES)) delay
  (
    .ref_clk(ref_clk),
    .rst_b(rst_b),
    .start(wakeStart),
    .crystalMode(crystalMode),
    .lowPowerSleep(lowPowerSleepSelect),
    .oscTick(oscTick),
    .done(delayDone)
  );
  // Reset-type wake requests arrive from pins and pass two flip-flops.
  always @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      resetPinSync <= 2'b00;
      brownOutSync <= 2'b00;
    end
    else
    begin
      resetPinSync <= {resetPinSync[0], resetPinWake};
      brownOutSync <= {brownOutSync[0], brownOutWake};
    end
  end
  always @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      state <= RUN;
      cpuCycleEnable <= 1'b0;
      cpuHalt <= 1'b0;
      programMemoryHalt <= 1'b0;
      systemClockEnable <= 1'b1;
      peripheralClockEnable <= 1'b1;
      clockOutputEnable <= 1'b1;
      watchdogClear <= 1'b0;
      watchdogRun <= 1'b1;
      regulatorLowPower <= 1'b0;
      deviceResetRequest <= 1'b0;
      vectorRequest <= 1'b0;
      vectorAddress <= 16'h0000;
      powerDownFlag <= 1'b1;
      timeoutFlag <= 1'b1;
      dozeEnable <= 1'b0;
      recoverOnInterrupt <= 1'b0;
      dozeOnExit <= 1'b0;
      idleEnable <= 1'b0;
      dozeRatio <= 3'h0;
      portDrive <= 8'h00;
      portEnable <= 8'h00;
      vectorPending <= 1'b0;
      wakeStart <= 1'b0;
    end
    else
    begin
      watchdogClear <= 1'b0;
      vectorRequest <= 1'b0;
      deviceResetRequest <= 1'b0;
      wakeStart <= 1'b0;
      idleEnable <= idleEnableIn;
      if (dozeRatioWrite)
        dozeRatio <= dozeRatioIn;
      if (dozeCtrlWrite)
        recoverOnInterrupt <= recoverOnInterruptIn;
      // Hardware events on the doze bits win over a software write.
      if (isrEntry)
      begin
        dozeOnExit <= dozeEnable;
        if (recoverOnInterrupt)
          dozeEnable <= 1'b0;
        // Otherwise dozeEnable keeps its value.
      end
      else if (isrReturn)
        dozeEnable <= dozeOnExit;
      else if (dozeCtrlWrite)
      begin
        dozeEnable <= dozeEnableIn;
        dozeOnExit <= dozeOnExitIn;
      end
      // The CPU cycle enable is suppressed outside the run mode.
      cpuCycleEnable <= (state == RUN) & throttleEnable;
      if (pinsFollow(state))
      begin
        portDrive <= portDriveIn;
        portEnable <= portEnableIn;
      end
      else
        portDrive <= sleepDrive;
      // Mode sequencing: run, sleep, wake delay and idle.
      case (state)
        RUN:
        begin
          if (vectorPending && nextInstrDone)
          begin
            vectorPending <= 1'b0;
            vectorRequest <= 1'b1;
            vectorAddress <= `ISR_VECTOR;
          end
          if (sleepInstr && interruptPendingEnabled && !idleEnable)
          begin
            // Sleep acts as a no-op; flags and watchdog untouched.
          end
          else if (sleepInstr && idleEnable)
          begin
            state <= IDLE;
            cpuHalt <= 1'b1;
            programMemoryHalt <= 1'b1;
          end
          else if (sleepInstr)
          begin
            state <= SLEEP;
            watchdogClear <= 1'b1;
            watchdogRun <= watchdogSleepEnable;
            powerDownFlag <= 1'b0;
            timeoutFlag <= 1'b1;
            cpuHalt <= 1'b1;
            programMemoryHalt <= 1'b1;
            systemClockEnable <= 1'b0;
            peripheralClockEnable <= 1'b0;
            clockOutputEnable <= 1'b0;
            regulatorLowPower <= lowPowerSleepSelect;
          end
        end
        SLEEP:
        begin
          if (resetWake)
          begin
            deviceResetRequest <= 1'b1;
            watchdogClear <= 1'b1;
            state <= WAKE;
            wakeStart <= 1'b1;
          end
          else if (intWake)
          begin
            // Wake needs individual enables only; global enable decides only whether the vector follows.
            watchdogClear <= 1'b1;
            vectorPending <= globalInterruptEnable & interruptPendingEnabled;
            state <= WAKE;
            wakeStart <= 1'b1;
          end
        end
        WAKE:
        begin
          regulatorLowPower <= 1'b0;
          if (delayDone)
          begin
            // Resume with the prefetched instruction.
            state <= RUN;
            cpuHalt <= 1'b0;
            programMemoryHalt <= 1'b0;
            systemClockEnable <= 1'b1;
            peripheralClockEnable <= 1'b1;
            clockOutputEnable <= 1'b1;
            watchdogRun <= 1'b1;
          end
        end
        IDLE:
        begin
          if (anyInterruptFlag || watchdogTimeout)
          begin
            // Interrupt path with global enable recovers via isrEntry; watchdog wake leaves doze alone.
            state <= RUN;
            cpuHalt <= 1'b0;
            programMemoryHalt <= 1'b0;
            vectorPending <= anyInterruptFlag & globalInterruptEnable;
            // Without global enable no handler entry follows, so recover here.
            if (anyInterruptFlag && recoverOnInterrupt && !globalInterruptEnable)
              dozeEnable <= 1'b0;
          end
        end
        default:
          state <= RUN;
      endcase
    end
  end
endmodule // power_saving_mode_control

// ### shared/power_mode_defs.vh
// Constants for the power-saving mode controller.
// Assumes inclusion by bare name from design files.
`ifndef POWER_MODE_DEFS_VH
`define POWER_MODE_DEFS_VH
`define DOZE_RATIO_W 3
`define DOZE_CNT_W 8
`define ISR_VECTOR 16'h0004
`define OSC_STARTUP_PERIODS 1024
`define OSC_CNT_W 11
`define LP_STABILISE_CYCLES 16
`define LP_CNT_W 5
`define MODE_RUN 4'h1
`define MODE_SLEEP 4'h2
`define MODE_IDLE 4'h4
`define MODE_WAKE 4'h8
`endif

// ### design/doze_throttle.v
// Doze throttle: gates one CPU cycle enable per ratio period.
// Assumes instrTick marks each instruction cycle on ref_clk.
`timescale 1ns/1ns
`include "power_mode_defs.vh"
module doze_throttle
(
  input wire ref_clk,
  input wire rst_b,
  input wire instrTick,
  input wire dozeEnable,
  input wire [`DOZE_RATIO_W-1:0] dozeRatio,
  output reg cpuCycleEnable
);
  reg [`DOZE_CNT_W-1:0] count;
  reg lastDoze;
  wire [`DOZE_CNT_W-1:0] lastCount;
  wire [3:0] shiftAmount;
  // The shift amount is one bit wider so that code 111 reaches a period of 256.
  assign shiftAmount = {1'b0, dozeRatio} + 4'h1;
  // Period is 2 << ratio, so the terminal count is that minus one.
  assign lastCount = ({{(`DOZE_CNT_W-1){1'b0}}, 1'b1} << shiftAmount) - 8'h01;
  always @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      count <= 8'h00;
      lastDoze <= 1'b0;
      cpuCycleEnable <= 1'b0;
    end
    else
    begin
      lastDoze <= dozeEnable;
      if (dozeEnable != lastDoze)
      begin
        count <= 8'h00;
        cpuCycleEnable <= 1'b0;
      end
      else if (!dozeEnable)
      begin
        cpuCycleEnable <= instrTick;
      end
      else if (instrTick)
      begin
        cpuCycleEnable <= (count == 8'h00);
        count <= (count >= lastCount) ? 8'h00 : count + 8'h01;
      end
      else
      begin
        cpuCycleEnable <= 1'b0;
      end
    end
  end
endmodule // doze_throttle

// ### design/wake_delay.v
// Wake delay counter for oscillator start-up and regulator settling.
// Assumes oscTick pulses once per oscillator period, same clock.
`timescale 1ns/1ns
`include "power_mode_defs.vh"
module wake_delay
#(
  parameter OSC_PERIODS = `OSC_STARTUP_PERIODS,
  parameter LP_CYCLES = `LP_STABILISE_CYCLES
)
(
  input wire ref_clk,
  input wire rst_b,
  input wire start,
  input wire crystalMode,
  input wire lowPowerSleep,
  input wire oscTick,
  output reg done
);
  reg [`OSC_CNT_W-1:0] oscCount;
  reg [`LP_CNT_W-1:0] lpCount;
  reg busy;
  wire oscDone;
  wire lpDone;
  assign oscDone = (oscCount == {`OSC_CNT_W{1'b0}});
  assign lpDone = (lpCount == {`LP_CNT_W{1'b0}});
  always @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      oscCount <= {`OSC_CNT_W{1'b0}};
      lpCount <= {`LP_CNT_W{1'b0}};
      busy <= 1'b0;
      done <= 1'b0;
    end
    else
    begin
      done <= 1'b0;
      if (start)
      begin
        busy <= 1'b1;
        oscCount <= crystalMode ? OSC_PERIODS[`OSC_CNT_W-1:0] : {`OSC_CNT_W{1'b0}};
        lpCount <= lowPowerSleep ? LP_CYCLES[`LP_CNT_W-1:0] : {`LP_CNT_W{1'b0}};
      end
      else if (busy)
      begin
        if (!oscDone && oscTick)
          oscCount <= oscCount - 11'h001;
        if (!lpDone)
          lpCount <= lpCount - 5'h01;
        if (oscDone && lpDone)
        begin
          busy <= 1'b0;
          done <= 1'b1;
        end
      end
    end
  end
endmodule // wake_delay

// ### testbench/psm_chk.sv
// Assertions on the power-saving mode controller ports.
// Bound into every controller instance.
`timescale 1ns/1ns
module psm_chk
(
  input wire ref_clk,
  input wire rst_b,
  input wire sleepInstr,
  input wire isrEntry,
  input wire isrReturn,
  input wire interruptPendingEnabled,
  input wire anyInterruptFlag,
  input wire watchdogTimeout,
  input wire globalInterruptEnable,
  input wire cpuCycleEnable,
  input wire cpuHalt,
  input wire programMemoryHalt,
  input wire peripheralClockEnable,
  input wire watchdogClear,
  input wire deviceResetRequest,
  input wire vectorRequest,
  input wire [15:0] vectorAddress,
  input wire powerDownFlag,
  input wire timeoutFlag,
  input wire dozeEnable,
  input wire recoverOnInterrupt,
  input wire dozeOnExit,
  input wire idleEnable,
  input wire [2:0] dozeRatio
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_b);
  reg idleSeen;
  // Remembers that the current halt was entered as Idle.
  always @(posedge ref_clk or negedge rst_b)
    if (!rst_b)
      idleSeen <= 1'h0;
    else if (!cpuHalt)
      idleSeen <= sleepInstr && idleEnable;
  sequence sleepGo;
    sleepInstr && !cpuHalt && !idleEnable && !interruptPendingEnabled;
  endsequence
  sequence sleepIn;
    cpuHalt && !powerDownFlag && timeoutFlag && watchdogClear;
  endsequence
  doe_copy_a: assert property (isrEntry |=> dozeOnExit == $past(dozeEnable))
    else $error("doze exit copy");
  roi_clear_a: assert property (isrEntry && recoverOnInterrupt |=> !dozeEnable)
    else $error("doze not cleared");
  roi_keep_a: assert property (isrEntry && !recoverOnInterrupt |=> $stable(dozeEnable))
    else $error("doze changed");
  exit_doze_a: assert property (isrReturn && !isrEntry |=> dozeEnable == $past(dozeOnExit))
    else $error("doze on return");
  sleep_entry_a: assert property (sleepGo |=> sleepIn)
    else $error("sleep entry");
  sleep_noop_a: assert property (sleepInstr && !cpuHalt && !idleEnable && interruptPendingEnabled
    |=> !cpuHalt && !watchdogClear && $stable(powerDownFlag) && $stable(timeoutFlag))
    else $error("sleep not a no-op");
  idle_entry_a: assert property (sleepInstr && !cpuHalt && idleEnable
    && !anyInterruptFlag && !watchdogTimeout |=> cpuHalt && programMemoryHalt
    && peripheralClockEnable && powerDownFlag == $past(powerDownFlag))
    else $error("idle entry");
  idle_exit_a: assert property (idleSeen && cpuHalt && (anyInterruptFlag || watchdogTimeout)
    |=> !cpuHalt && !deviceResetRequest)
    else $error("idle exit");
  vector_addr_a: assert property (vectorRequest |-> vectorAddress == 16'h0004
    && globalInterruptEnable)
    else $error("vector");
  doze_gap_a: assert property (cpuCycleEnable && dozeEnable && dozeRatio == 3'h1
    |=> (!cpuCycleEnable || !dozeEnable || dozeRatio != 3'h1) [*3])
    else $error("doze gap");
  idle_recover_a: assert property (idleSeen && cpuHalt && anyInterruptFlag && recoverOnInterrupt
    && !globalInterruptEnable |=> !dozeEnable)
    else $error("idle recovery");
  idle_wdt_a: assert property (idleSeen && cpuHalt && watchdogTimeout && !anyInterruptFlag
    && !isrEntry && !isrReturn |=> $stable(dozeEnable))
    else $error("idle watchdog doze");
endmodule // psm_chk
bind power_saving_mode_control psm_chk chk (.*);

// ### testbench/cpu_model.sv
// Stand-in for the CPU core and the oscillator ticks.
// Shares ref_clk and rst_b with the controller.
`timescale 1ns/1ns
module cpu_model
(
  input wire ref_clk,
  input wire rst_b,
  input wire cpuHalt,
  output reg instrTick,
  output reg oscTick,
  output reg nextInstrDone
);
  reg wasHalt;
  // Ticks every other cycle; the prefetched instruction retires once released.
  always @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      instrTick <= 1'h0;
      oscTick <= 1'h0;
      nextInstrDone <= 1'h0;
      wasHalt <= 1'h0;
    end
    else
    begin
      instrTick <= !instrTick;
      oscTick <= instrTick;
      nextInstrDone <= wasHalt && !cpuHalt;
      wasHalt <= cpuHalt;
    end
  end
endmodule // cpu_model

// ### testbench/testbench.sv
// Self-checking bench for the power-saving mode controller.
// Uses cpu_model for ticks; the checker is bound in.
`timescale 1ns/1ns
module testbench;
  reg ref_clk = 1'h0, rst_b = 1'h0, sleepInstr = 1'h0, isrEntry = 1'h0, isrReturn = 1'h0;
  reg idleEnableIn = 1'h0, dozeRatioWrite = 1'h0, dozeCtrlWrite = 1'h0, dozeEnableIn = 1'h0;
  reg recoverOnInterruptIn = 1'h0, dozeOnExitIn = 1'h0, lowPowerSleepSelect = 1'h0;
  reg globalInterruptEnable = 1'h0, interruptPendingEnabled = 1'h0, anyInterruptFlag = 1'h0;
  reg watchdogTimeout = 1'h0, watchdogSleepEnable = 1'h0, resetPinWake = 1'h0;
  reg brownOutWake = 1'h0, crystalMode = 1'h0;
  reg [2:0] dozeRatioIn = 3'h0;
  reg [7:0] portDriveIn = 8'h0, portEnableIn = 8'h0, asyncPeriphMask = 8'h0;
  reg [7:0] asyncPeriphDrive = 8'h0;
  wire instrTick, oscTick, nextInstrDone, cpuCycleEnable, cpuHalt, programMemoryHalt;
  wire systemClockEnable, peripheralClockEnable, clockOutputEnable, watchdogClear;
  wire watchdogRun, regulatorLowPower, deviceResetRequest, vectorRequest, powerDownFlag;
  wire timeoutFlag, dozeEnable, recoverOnInterrupt, dozeOnExit, idleEnable;
  wire [15:0] vectorAddress;
  wire [2:0] dozeRatio;
  wire [7:0] portDrive, portEnable;
  integer fails = 0, n_checks = 0, cyc = 0, pulses = 0, vecs = 0, rsts = 0, i, k, lat;
  power_saving_mode_control #(.OSC_PERIODS(8), .LP_CYCLES(12)) dut (.*);
  cpu_model cpu (.*);
  always #10 ref_clk = ~ref_clk;
  always @(posedge ref_clk)
  begin
    cyc <= cyc + 1;
    if (cpuCycleEnable === 1'h1)
      pulses <= pulses + 1;
    if (vectorRequest === 1'h1)
      vecs <= vecs + 1;
    if (deviceResetRequest === 1'h1)
      rsts <= rsts + 1;
    if (cyc == 20000)
    begin
      fails = fails + 1;
      wrap_up;
    end
  end
  task chk(input [15:0] seen, input [15:0] exp);
  begin
    n_checks = n_checks + 1;
    if (seen !== exp)
    begin
      fails = fails + 1;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  end
  endtask
  task step(input integer n);
  begin
    repeat (n) @(posedge ref_clk);
    #1;
  end
  endtask
  task ctl(input de, input recover_on_interrupt, input doze_on_exit);
  begin
    dozeEnableIn = de;
    recoverOnInterruptIn = recover_on_interrupt;
    dozeOnExitIn = doze_on_exit;
    dozeCtrlWrite = 1'h1;
    step(1);
    dozeCtrlWrite = 1'h0;
    step(1);
  end
  endtask
  task pulse_sleep;
  begin
    sleepInstr = 1'h1;
    step(1);
    sleepInstr = 1'h0;
  end
  endtask
  task wrap_up;
  begin
    $display("checks=%0d fails=%0d", n_checks, fails);
    if (fails == 0 && n_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  end
  endtask
  initial
  begin
    step(2);
    rst_b = 1'h1;
    for (i = 0; i < 9; i = i + 1)
    begin
      dozeRatioIn = i[2:0];
      dozeRatioWrite = 1'h1;
      step(1);
      dozeRatioWrite = 1'h0;
      ctl(i < 8, 1'h0, 1'h0);
      chk(dozeRatio, i[2:0]);
      step(20);
      pulses = 0;
      step(1024);
      chk(pulses, i < 8 ? 512 >> (i + 1) : 512);
    end
    for (i = 0; i < 8; i = i + 1)
    begin
      ctl(i[0], i[1], !i[0]);
      isrEntry = 1'h1;
      step(1);
      isrEntry = 1'h0;
      step(1);
      chk(dozeOnExit, i[0]);
      chk(dozeEnable, i[0] & !i[1]);
      chk(recoverOnInterrupt, i[1]);
      ctl(dozeEnable, i[1], i[2]);
      isrReturn = 1'h1;
      step(1);
      isrReturn = 1'h0;
      step(1);
      chk(dozeEnable, i[2]);
    end
    ctl(1'h0, 1'h0, 1'h0);
    interruptPendingEnabled = 1'h1;
    pulse_sleep;
    step(1);
    chk({cpuHalt, powerDownFlag, timeoutFlag}, 3'h3);
    for (k = 0; k < 5; k = k + 1)
    begin
      crystalMode = k == 1;
      lowPowerSleepSelect = k == 2;
      globalInterruptEnable = k == 1;
      watchdogSleepEnable = k[0];
      portDriveIn = 8'ha5;
      portEnableIn = 8'h3c;
      asyncPeriphMask = 8'h0f;
      asyncPeriphDrive = 8'h03;
      interruptPendingEnabled = 1'h0;
      step(2);
      pulse_sleep;
      interruptPendingEnabled = k == 1;
      portDriveIn = 8'h5a;
      portEnableIn = 8'hc3;
      vecs = 0;
      rsts = 0;
      chk({cpuHalt, powerDownFlag, timeoutFlag, watchdogClear}, 4'hb);
      chk({watchdogRun, regulatorLowPower}, {k[0], k == 2});
      chk({programMemoryHalt, systemClockEnable, clockOutputEnable}, 3'h4);
      step(1);
      chk({portDrive, portEnable}, 16'ha33c);
      if (k == 1)
        chk(watchdogClear, 1'h1);
      if (k == 0)
      begin
        anyInterruptFlag = 1'h1;
        step(10);
        chk(cpuHalt, 1'h1);
        anyInterruptFlag = 1'h0;
      end
      interruptPendingEnabled = k < 3;
      resetPinWake = k == 3;
      brownOutWake = k == 4;
      step(1);
      if (k == 0 || k == 2)
        chk(watchdogClear, 1'h1);
      wake(lat);
      chk(lat >= (k == 1 ? 14 : k == 2 ? 10 : 0), 1'h1);
      chk(lat < 10, k != 1 && k != 2);
      step(6);
      chk({vecs > 0, rsts > 0}, {k == 1, k > 2});
      if (k == 1)
        chk(vectorAddress, 16'h0004);
      resetPinWake = 1'h0;
      brownOutWake = 1'h0;
    end
    interruptPendingEnabled = 1'h0;
    globalInterruptEnable = 1'h0;
    ctl(1'h1, 1'h1, 1'h0);
    idleEnableIn = 1'h1;
    for (k = 0; k < 2; k = k + 1)
    begin
      rsts = 0;
      step(2);
      pulse_sleep;
      step(1);
      chk({cpuHalt, programMemoryHalt, peripheralClockEnable}, 3'h7);
      chk({systemClockEnable, clockOutputEnable, idleEnable}, 3'h7);
      step(5);
      watchdogTimeout = k == 0;
      anyInterruptFlag = k == 1;
      step(2);
      watchdogTimeout = 1'h0;
      anyInterruptFlag = 1'h0;
      chk({cpuHalt, idleEnable, rsts > 0, dozeEnable}, {3'h2, k == 0});
    end
    wrap_up;
  end
  task wake(output integer n);
  begin
    n = 0;
    while (cpuHalt !== 1'h0 && n < 200)
    begin
      step(1);
      n = n + 1;
    end
  end
  endtask
endmodule // testbench
